// file: core/dce_core.sv
// descriptor driven multi channel byte mover with avalon register slave
module dce_core (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic o_avs_waitrequest,
    output logic [31:0] o_avs_readdata,
    input wire logic [dce_pkg::NCH-1:0] i_dreq,
    input wire logic [dce_pkg::NCH-1:0] i_term_in,
    input wire logic i_cpu_req,
    output logic o_mem_req,
    output dce_pkg::dce_mem_req_t o_mem,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    output logic [dce_pkg::NCH-1:0] o_term_out
);
    import dce_pkg::*;

    // bytes in one swap group, minus one
    function automatic logic [1:0] grp_max(input dce_flags_t f);
        return !f.swap_en ? 2'h0 : (f.swap4 ? 2'h3 : 2'h1);
    endfunction

    // replaces the byte lanes that are enabled
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
            input logic [31:0] new_v, input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // descriptor store and channel state
    dce_td_t td_q [TD_NUM];
    logic [TDW-1:0] td_sel_q;
    logic [NCH-1:0] en_q;
    logic [NCH-1:0] pb_q;
    logic [NCH-1:0][2:0] prio_q;
    logic [7:0] bpb_q [NCH];
    logic [31:0] hi_q [NCH];
    logic [TDW-1:0] cur_q [NCH];
    logic [NCH-1:0] loaded_q;
    logic [11:0] rem_q [NCH];
    logic [15:0] src_q [NCH];
    logic [15:0] dst_q [NCH];
    logic [NCH-1:0] pend_q;
    logic [NCH-1:0] cont_q;
    logic [NCH-1:0] done_q;
    logic [NCH-1:0] tprev_q;

    // engine state
    dce_state_t state_q;
    logic [CW-1:0] ach_q;
    logic [7:0] blft_q;
    logic [1:0] gi_q;
    logic [7:0] buf_q [4];
    logic term_q;

    // bus decode
    logic bus_we;
    logic is_ch;
    logic [CW-1:0] bch;
    logic [1:0] breg;
    logic wr_st, wr_sel, wr_tda, wr_tdc;
    logic wr_cfg, wr_hi, wr_td, wr_req;
    logic [31:0] rd_val;
    logic [31:0] wm;
    logic [31:0] st_clr;
    assign bus_we = i_avs_write && !o_avs_waitrequest;
    assign is_ch = i_avs_address[11:8] == CH_PAGE
        && i_avs_address[7:6] == 2'h0;
    assign bch = i_avs_address[5:4];
    assign breg = i_avs_address[3:2];
    assign wr_st = bus_we && i_avs_address == REG_STATUS;
    assign wr_sel = bus_we && i_avs_address == REG_TD_SEL;
    assign wr_tda = bus_we && i_avs_address == REG_TD_ADDR;
    assign wr_tdc = bus_we && i_avs_address == REG_TD_CTRL;
    assign wr_cfg = bus_we && is_ch && breg == CH_CFG;
    assign wr_hi = bus_we && is_ch && breg == CH_HI;
    assign wr_td = bus_we && is_ch && breg == CH_TD;
    assign wr_req = bus_we && is_ch && breg == CH_REQ;
    assign wm = be_merge(rd_val, i_avs_writedata, i_avs_byteenable);
    assign st_clr = i_avs_writedata
        & be_merge(32'h0000_0000, 32'hFFFF_FFFF, i_avs_byteenable);

    // engine decode
    dce_td_t tda;
    dce_td_t tdg;
    logic gnt_v;
    logic [CW-1:0] gnt_idx;
    logic [NCH-1:0] go;
    logic [1:0] gmax;
    logic busy, start, fin, rd_ack, wr_ack;
    logic grp_done, last_byte, burst_end, term_edge, chain_end;
    assign tda = td_q[cur_q[ach_q]];
    assign tdg = td_q[cur_q[gnt_idx]];
    assign gmax = grp_max(tda.flags);
    assign go = en_q & (pend_q | cont_q);
    assign busy = state_q != S_IDLE;
    assign start = state_q == S_IDLE && gnt_v;
    assign fin = state_q == S_FIN;
    assign rd_ack = state_q == S_RD && o_mem_req && i_mem_ack;
    assign wr_ack = state_q == S_WR && o_mem_req && i_mem_ack;
    assign grp_done = gi_q == gmax;
    assign last_byte = wr_ack
        && (rem_q[ach_q] == CNT_ONE || (grp_done && term_q));
    assign burst_end = wr_ack && !last_byte && grp_done
        && blft_q <= BPB_ONE;
    assign term_edge = (state_q == S_RD || state_q == S_WR)
        && i_term_in[ach_q] && !tprev_q[ach_q]
        && tda.flags.terminate_input_option;
    assign chain_end = tda.next == CHAIN_END;

    // channel arbitration among pending channels
    dce_prio_arb u_arb (
        .i_req(go),
        .i_prio(prio_q),
        .o_valid(gnt_v),
        .o_idx(gnt_idx)
    );

    // register read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_ch) begin
            case (breg)
                CH_CFG: rd_val = {16'h0000, bpb_q[bch], 3'h0, prio_q[bch],
                    pb_q[bch], en_q[bch]};
                CH_HI: rd_val = hi_q[bch];
                CH_TD: rd_val = {12'h000, rem_q[bch], loaded_q[bch],
                    cur_q[bch]};
                default: rd_val = {31'h0000_0000, pend_q[bch]};
            endcase
        end else begin
            case (i_avs_address)
                REG_STATUS: rd_val = {21'h00_0000, ach_q, busy, en_q, done_q};
                REG_TD_SEL: rd_val = {25'h000_0000, td_sel_q};
                REG_TD_ADDR: rd_val = {td_q[td_sel_q].dst_lo,
                    td_q[td_sel_q].src_lo};
                REG_TD_CTRL: rd_val = {td_q[td_sel_q].next, 5'h00,
                    td_q[td_sel_q].flags, td_q[td_sel_q].count};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    // one wait state per access, read data captured with it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write)
                && o_avs_waitrequest);
            o_avs_readdata <= rd_val;
        end
    end

    // descriptor store, written through the select window
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            td_sel_q <= '0;
            for (int i = 0; i < TD_NUM; i++) begin
                td_q[i] <= '0;
            end
        end else begin
            if (wr_sel) begin
                td_sel_q <= wm[TDW-1:0];
            end
            if (wr_tda) begin
                td_q[td_sel_q].src_lo <= wm[15:0];
                td_q[td_sel_q].dst_lo <= wm[31:16];
            end
            if (wr_tdc) begin
                td_q[td_sel_q].count <= wm[11:0];
                td_q[td_sel_q].flags <= wm[TDC_FLAG_LSB +: 7];
                td_q[td_sel_q].next <= wm[TDC_NEXT_LSB +: 8];
            end
        end
    end

    // per channel settings, pointers, requests and completion
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_q <= '0;
            pb_q <= '0;
            pend_q <= '0;
            cont_q <= '0;
            done_q <= '0;
            tprev_q <= '0;
            loaded_q <= '0;
            o_term_out <= '0;
            for (int c = 0; c < NCH; c++) begin
                prio_q[c] <= RST_PRIO;
                bpb_q[c] <= RST_BPB;
                hi_q[c] <= 32'h0000_0000;
                cur_q[c] <= '0;
                rem_q[c] <= 12'h000;
                src_q[c] <= 16'h0000;
                dst_q[c] <= 16'h0000;
            end
        end else begin
            tprev_q <= i_term_in;
            for (int c = 0; c < NCH; c++) begin
                o_term_out[c] <= fin && ach_q == CW'(c)
                    && tda.flags.termout;
                // a new request beats its consumption
                if (i_dreq[c] || (wr_req && bch == CW'(c) && wm[0])) begin
                    pend_q[c] <= 1'b1;
                end else if (start && gnt_idx == CW'(c) && !cont_q[c]) begin
                    pend_q[c] <= 1'b0;
                end
                // end of chain sets done, write one clears
                if (fin && ach_q == CW'(c) && chain_end) begin
                    done_q[c] <= 1'b1;
                end else if (wr_st && st_clr[c]) begin
                    done_q[c] <= 1'b0;
                end
                if (wr_cfg && bch == CW'(c)) begin
                    en_q[c] <= wm[CFG_EN_BIT];
                    pb_q[c] <= wm[CFG_PB_BIT];
                    prio_q[c] <= wm[CFG_PRIO_LSB +: 3];
                    bpb_q[c] <= wm[CFG_BPB_LSB +: 8];
                end else if (fin && ach_q == CW'(c) && chain_end) begin
                    en_q[c] <= 1'b0;
                end
                if (wr_hi && bch == CW'(c)) begin
                    hi_q[c] <= wm;
                end
                // automatic continuation of bursts and of the chain
                if (wr_td && bch == CW'(c)) begin
                    cont_q[c] <= 1'b0;
                end else if (ach_q == CW'(c) && burst_end && !pb_q[c]) begin
                    cont_q[c] <= 1'b1;
                end else if (ach_q == CW'(c) && fin && !chain_end
                        && tda.flags.auto_next) begin
                    cont_q[c] <= 1'b1;
                end else if (start && gnt_idx == CW'(c)) begin
                    cont_q[c] <= 1'b0;
                end
                // descriptor pointer and running counters
                if (wr_td && bch == CW'(c)) begin
                    cur_q[c] <= wm[TDW-1:0];
                    loaded_q[c] <= 1'b0;
                end else if (start && gnt_idx == CW'(c) && !loaded_q[c]) begin
                    loaded_q[c] <= 1'b1;
                    rem_q[c] <= tdg.count;
                    src_q[c] <= tdg.src_lo;
                    dst_q[c] <= tdg.dst_lo;
                end else if (ach_q == CW'(c)) begin
                    if (rd_ack && tda.flags.inc_src) begin
                        src_q[c] <= src_q[c] + 16'h0001;
                    end
                    if (wr_ack) begin
                        rem_q[c] <= rem_q[c] - CNT_ONE;
                    end
                    if (wr_ack && tda.flags.inc_dst) begin
                        dst_q[c] <= dst_q[c] + 16'h0001;
                    end
                    if (fin) begin
                        loaded_q[c] <= 1'b0;
                        if (!chain_end) begin
                            cur_q[c] <= tda.next[TDW-1:0];
                        end
                    end
                end
            end
        end
    end

    // burst sequencer: read a swap group, then write it back reversed
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= S_IDLE;
            ach_q <= '0;
            blft_q <= 8'h00;
            gi_q <= 2'h0;
            term_q <= 1'b0;
            for (int b = 0; b < 4; b++) begin
                buf_q[b] <= 8'h00;
            end
        end else begin
            if (term_edge) begin
                term_q <= 1'b1;
            end
            case (state_q)
                S_IDLE: begin
                    if (gnt_v) begin
                        ach_q <= gnt_idx;
                        // zero burst size behaves as one byte
                        blft_q <= (bpb_q[gnt_idx] == 8'h00) ? BPB_ONE
                            : bpb_q[gnt_idx];
                        gi_q <= 2'h0;
                        term_q <= 1'b0;
                        state_q <= S_CHK;
                    end
                end
                S_CHK: begin
                    state_q <= (rem_q[ach_q] == 12'h000) ? S_FIN : S_RD;
                end
                S_RD: begin
                    if (rd_ack) begin
                        buf_q[gi_q] <= i_mem_rdata;
                        gi_q <= grp_done ? 2'h0 : gi_q + 2'h1;
                        if (grp_done) begin
                            state_q <= S_WR;
                        end
                    end
                end
                S_WR: begin
                    if (wr_ack) begin
                        // saturates if burst size breaks the group size
                        blft_q <= (blft_q == 8'h00) ? 8'h00
                            : blft_q - BPB_ONE;
                        gi_q <= grp_done ? 2'h0 : gi_q + 2'h1;
                        if (last_byte) begin
                            state_q <= S_FIN;
                        end else if (burst_end) begin
                            state_q <= S_IDLE;
                        end else if (grp_done) begin
                            state_q <= S_RD;
                        end
                    end
                end
                S_FIN: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // hub port: one byte access at a time, held until acknowledged
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_req <= 1'b0;
            o_mem <= '0;
        end else if (!o_mem_req) begin
            if ((state_q == S_RD || state_q == S_WR) && !i_cpu_req) begin
                o_mem_req <= 1'b1;
                o_mem.we <= state_q == S_WR;
                o_mem.addr <= (state_q == S_RD)
                    ? {hi_q[ach_q][15:0], src_q[ach_q]}
                    : {hi_q[ach_q][31:16], dst_q[ach_q]};
                o_mem.wdata <= buf_q[2'(gmax - gi_q)];
            end
        end else if (i_mem_ack) begin
            o_mem_req <= 1'b0;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    property p_burst_stop;
        burst_end |=> state_q == S_IDLE;
    endproperty
    a_burst_stop: assert property (p_burst_stop)
        else $error("burst did not stop at its byte count");

    property p_auto_cont;
        burst_end && !pb_q[ach_q] |=> cont_q[$past(ach_q)];
    endproperty
    a_auto_cont: assert property (p_auto_cont)
        else $error("later burst not armed without request");

    property p_chain_off;
        fin && chain_end |=> !en_q[$past(ach_q)] && done_q[$past(ach_q)];
    endproperty
    a_chain_off: assert property (p_chain_off)
        else $error("channel still enabled after chain end");

    property p_term_catch;
        term_edge |=> term_q;
    endproperty
    a_term_catch: assert property (p_term_catch)
        else $error("termination edge lost");

    property p_tout_pulse;
        fin && tda.flags.termout |=> (o_term_out != '0) ##1 (o_term_out == '0);
    endproperty
    a_tout_pulse: assert property (p_tout_pulse)
        else $error("termination output not a single pulse");

    property p_src_step;
        rd_ack && tda.flags.inc_src
            |=> src_q[$past(ach_q)] == $past(src_q[ach_q]) + 16'h0001;
    endproperty
    a_src_step: assert property (p_src_step)
        else $error("source address did not advance");

    property p_dst_step;
        wr_ack && tda.flags.inc_dst
            |=> dst_q[$past(ach_q)] == $past(dst_q[ach_q]) + 16'h0001;
    endproperty
    a_dst_step: assert property (p_dst_step)
        else $error("destination address did not advance");

    property p_cpu_first;
        i_cpu_req && !o_mem_req |=> !o_mem_req;
    endproperty
    a_cpu_first: assert property (p_cpu_first)
        else $error("engine took the hub over the processor");

    property p_count_done;
        wr_ack && rem_q[ach_q] == CNT_ONE |=> state_q == S_FIN;
    endproperty
    a_count_done: assert property (p_count_done)
        else $error("descriptor not finished at zero count");

endmodule // dce_core

// file: core/dce_prio_arb.sv
// channel arbiter: picks the pending channel with the best priority level
module dce_prio_arb (
    input wire logic [dce_pkg::NCH-1:0] i_req,
    input wire logic [dce_pkg::NCH-1:0][2:0] i_prio,
    output logic o_valid,
    output logic [dce_pkg::CW-1:0] o_idx
);
    import dce_pkg::*;

    // level 0 is best, lower channel number breaks a tie
    always_comb begin
        logic [2:0] best;
        best = 3'h7;
        o_valid = 1'b0;
        o_idx = '0;
        for (int c = 0; c < NCH; c++) begin
            if (i_req[c] && (!o_valid || i_prio[c] < best)) begin
                o_valid = 1'b1;
                o_idx = CW'(c);
                best = i_prio[c];
            end
        end
    end

endmodule // dce_prio_arb

// file: include/dce_pkg.sv
// shared constants, register map and carrier types of the descriptor engine
package dce_pkg;

    // channel count and descriptor store size
    localparam int NCH = 4;
    localparam int CW = 2;
    localparam int TD_NUM = 128;
    localparam int TDW = 7;
    localparam logic [7:0] CHAIN_END = 8'hFE;

    // global register byte addresses
    localparam logic [11:0] REG_STATUS = 12'h000;
    localparam logic [11:0] REG_TD_SEL = 12'h004;
    localparam logic [11:0] REG_TD_ADDR = 12'h008;
    localparam logic [11:0] REG_TD_CTRL = 12'h00C;

    // channel page: 0x100 + channel * 0x10 + register * 4
    localparam logic [3:0] CH_PAGE = 4'h1;
    localparam logic [1:0] CH_CFG = 2'h0;
    localparam logic [1:0] CH_HI = 2'h1;
    localparam logic [1:0] CH_TD = 2'h2;
    localparam logic [1:0] CH_REQ = 2'h3;

    // field positions
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_PB_BIT = 1;
    localparam int CFG_PRIO_LSB = 2;
    localparam int CFG_BPB_LSB = 8;
    localparam int TDC_FLAG_LSB = 12;
    localparam int TDC_NEXT_LSB = 24;

    // values after reset and small counts
    localparam logic [7:0] RST_BPB = 8'h01;
    localparam logic [2:0] RST_PRIO = 3'h0;
    localparam logic [11:0] CNT_ONE = 12'h001;
    localparam logic [7:0] BPB_ONE = 8'h01;

    // descriptor option bits, msb first
    typedef struct packed {
        logic swap_en;
        logic swap4;
        logic auto_next;
        logic terminate_input_option;
        logic termout;
        logic inc_dst;
        logic inc_src;
    } dce_flags_t;

    // one transaction descriptor
    typedef struct packed {
        logic [7:0] next;
        dce_flags_t flags;
        logic [11:0] count;
        logic [15:0] dst_lo;
        logic [15:0] src_lo;
    } dce_td_t;

    // byte access towards the peripheral hub
    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [7:0] wdata;
    } dce_mem_req_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_CHK,
        S_RD,
        S_WR,
        S_FIN
    } dce_state_t;

endpackage

// file: testbench/dce_core_tb.sv
// register driven transfers through the descriptor engine
module dce_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dce_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [11:0] adr = 12'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [NCH-1:0] dreq = '0;
    logic [NCH-1:0] term = '0;
    logic cpu = 1'b0;
    logic wait_r;
    logic [31:0] rdat;
    logic mreq;
    logic ack;
    logic [7:0] mrd;
    dce_mem_req_t mem;
    logic [NCH-1:0] tout;
    logic [31:0] w_adr;
    logic [7:0] w_dat;
    logic [7:0] w_cnt;
    int err_count = 0;
    int n_checks = 0;
    int n_term = 0;
    logic [31:0] v;

    dce_core dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(4'hF), .o_avs_waitrequest(wait_r),
        .o_avs_readdata(rdat), .i_dreq(dreq), .i_term_in(term),
        .i_cpu_req(cpu), .o_mem_req(mreq), .o_mem(mem), .i_mem_ack(ack),
        .i_mem_rdata(mrd), .o_term_out(tout));
    dce_mem_model mem_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(mreq),
        .i_mem(mem), .o_ack(ack), .o_rdata(mrd), .o_wr_addr(w_adr),
        .o_wr_data(w_dat), .o_wr_cnt(w_cnt));

    // clock and termination pulse counter
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (tout != 4'h0) n_term++;
    end

    task automatic test_done();
        if (err_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (exp !== got) begin
            err_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask

    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic we, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk);
        adr <= a;
        rd <= !we;
        wr <= we;
        wd <= d;
        do begin
            @(posedge i_clk);
        end while (wait_r !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // poll status until chain done bit of a channel is set
    task automatic wait_done(input int ch);
        do begin
            bus(1'b0, REG_STATUS, 32'h0, v);
        end while (v[ch] !== 1'b1);
    endtask

    // wait until the far side has counted k byte writes
    task automatic wait_wr(input logic [7:0] k);
        do begin
            @(posedge i_clk);
        end while (w_cnt !== k);
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        bus(1'b0, 12'h100, 32'h0, v);
        check("cfg reset", 32'h0000_0100, v);
        bus(1'b0, 12'h7F0, 32'h0, v);
        check("unmapped", 32'h0, v);
        // ch0: 4 bytes, bursts of 2, 2-byte swap, both increments
        bus(1'b1, REG_TD_SEL, 32'h0, v);
        bus(1'b1, REG_TD_ADDR, 32'h0020_0010, v);
        bus(1'b1, REG_TD_CTRL, 32'hFE04_7004, v);
        bus(1'b1, 12'h104, 32'h0002_0001, v);
        bus(1'b1, 12'h108, 32'h0, v);
        bus(1'b1, 12'h100, 32'h0000_0201, v);
        bus(1'b1, 12'h10C, 32'h1, v);
        wait_done(0);
        check("status", 32'h1, v & 32'h0000_0011);
        check("writes", 32'd4, {24'h0, w_cnt});
        check("last addr", 32'h0002_0023, w_adr);
        check("last data", 32'h48, {24'h0, w_dat});
        check("term out", 32'd1, n_term);
        bus(1'b0, 12'h108, 32'h0, v);
        check("remaining", 32'h0, {20'h0, v[19:8]});
        // ch1: request per burst, two single byte bursts
        bus(1'b1, REG_TD_SEL, 32'h1, v);
        bus(1'b1, REG_TD_ADDR, 32'h0030_0040, v);
        bus(1'b1, REG_TD_CTRL, 32'hFE00_0002, v);
        bus(1'b1, 12'h118, 32'h1, v);
        bus(1'b1, 12'h110, 32'h0000_0103, v);
        bus(1'b1, 12'h11C, 32'h1, v);
        repeat (40) @(posedge i_clk);
        check("one burst", 32'd5, {24'h0, w_cnt});
        check("dst fixed", 32'h0000_0030, w_adr);
        bus(1'b1, 12'h11C, 32'h1, v);
        wait_done(1);
        check("two bursts", 32'd6, {24'h0, w_cnt});
        check("ch1 done", 32'h2, v & 32'h0000_0022);
        check("term out off", 32'd1, n_term);
        // ch3 outranks ch2 while the processor holds the hub
        bus(1'b1, REG_TD_SEL, 32'h2, v);
        bus(1'b1, REG_TD_ADDR, 32'h0060_0050, v);
        bus(1'b1, REG_TD_CTRL, 32'h0407_3008, v);
        bus(1'b1, REG_TD_SEL, 32'h4, v);
        bus(1'b1, REG_TD_ADDR, 32'h00A0_0090, v);
        bus(1'b1, REG_TD_CTRL, 32'hFE00_F020, v);
        bus(1'b1, REG_TD_SEL, 32'h5, v);
        bus(1'b1, REG_TD_ADDR, 32'h0080_0070, v);
        bus(1'b1, REG_TD_CTRL, 32'hFE00_0001, v);
        bus(1'b1, 12'h124, 32'h0004_0003, v);
        bus(1'b1, 12'h128, 32'h2, v);
        bus(1'b1, 12'h120, 32'h0000_2015, v);
        bus(1'b1, 12'h138, 32'h5, v);
        bus(1'b1, 12'h130, 32'h0000_0109, v);
        @(posedge i_clk);
        cpu <= 1'b1;
        dreq <= 4'hC;
        @(posedge i_clk);
        dreq <= 4'h0;
        repeat (20) @(posedge i_clk);
        check("held req", 32'h0, {31'h0, mreq});
        check("held writes", 32'h6, {24'h0, w_cnt});
        cpu <= 1'b0;
        wait_done(3);
        check("ch3 done", 32'h8, v & 32'h0000_0088);
        check("first winner", 32'h7, {24'h0, w_cnt});
        check("ch3 addr", 32'h0000_0080, w_adr);
        // ch2: 4-byte swap, auto chain, then a cut descriptor
        wait_wr(8'h0F);
        check("swap addr", 32'h0004_0067, w_adr);
        check("swap data", 32'h0E, {24'h0, w_dat});
        wait_wr(8'h12);
        term <= 4'h4;
        wait_done(2);
        term <= 4'h0;
        check("ch2 done", 32'h4, v & 32'h0000_0044);
        check("cut writes", 32'h13, {24'h0, w_cnt});
        check("cut addr", 32'h0004_00A3, w_adr);
        check("cut data", 32'hC9, {24'h0, w_dat});
        check("term out 2", 32'h2, n_term);
        bus(1'b0, 12'h128, 32'h0, v);
        check("ch2 td", 32'h0000_1C04, v);
        test_done();
    end

    // watchdog
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule // dce_core_tb

// file: testbench/dce_mem_model.sv
// hub side byte memory model answering engine accesses
module dce_mem_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire dce_pkg::dce_mem_req_t i_mem,
    output logic o_ack,
    output logic [7:0] o_rdata,
    output logic [31:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic [7:0] o_wr_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    import dce_pkg::*;
    logic [7:0] last_q;
    // ack one cycle after a request is seen; read byte follows address
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            o_rdata <= 8'h00;
            last_q <= 8'h00;
            o_wr_addr <= 32'h0000_0000;
            o_wr_data <= 8'h00;
            o_wr_cnt <= 8'h00;
        end else begin
            o_ack <= i_req && !o_ack;
            // data only valid with ack, otherwise inverse of last
            o_rdata <= (i_req && !o_ack) ? (i_mem.addr[7:0] ^ 8'h5A) : ~last_q;
            if (i_req && !o_ack) begin
                last_q <= i_mem.addr[7:0] ^ 8'h5A;
            end
            if (i_req && o_ack && i_mem.we) begin
                o_wr_addr <= i_mem.addr;
                o_wr_data <= i_mem.wdata;
                o_wr_cnt <= o_wr_cnt + 8'h01;
            end
        end
    end
endmodule // dce_mem_model
